/* rtl/pss_phy_regs.sv */
// Per-port PHY gigabit status, MMD indirect access, extended status and loopback registers
//
// Functional notes
// [RULE1] Fault bit 15 latches high, clears after read
// [RULE2] Bit 14 shows master (1) or slave
// [RULE3] Bit 13 shows local receiver OK
// [RULE4] Bit 12 shows remote receiver OK
// [RULE5] Bits 11/10 show partner gigabit full/half
// [RULE6] 8-bit idle error count, clears on read
// [RULE7] Count each erroneous idle symbol period; counted only while transmit mode is TXMODE_SEND_N
// [RULE8] Setup bits 15:14 select operation mode
// [RULE9] Setup bits 4:0 select MMD device; only bits 1:0 reach the storage index
// [RULE10] Mode 00: data register is register address
// [RULE11] Data modes: data register is device data
// [RULE12] Mode 10: address increments on read, write
// [RULE13] Mode 11 increments on writes; 01 never
// [RULE14] Extended status reads 0x3000 fixed
// [RULE15] Loopback bit 8 loops receive to transmit
// [RULE16] Receive pair data retransmitted on transmit pair
// [RULE17] Idle counter saturates at 255
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module pss_phy_regs
  import pss_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic ms_fault_evt_i,
  input wire logic ms_master_i,
  input wire logic local_rx_ok_i,
  input wire logic remote_rx_ok_i,
  input wire logic lp_1000_fd_i,
  input wire logic lp_1000_hd_i,
  input wire logic symbol_tick_i,
  input wire logic rx_idle_i,
  input wire logic [1:0] transmit_mode_indication_i,
  input wire logic rx_error_i,
  input wire logic [RX_DATA_W-1:0] rx_data_i,
  input wire logic rx_dv_i,
  input wire logic [RX_DATA_W-1:0] sw_tx_data_i,
  input wire logic sw_tx_en_i,
  output logic [RX_DATA_W-1:0] tx_data_o,
  output logic tx_en_o,
  output logic remote_loopback_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic ms_fault;
    logic [DATA_W-1:0] mmd_setup;
    logic [DATA_W-1:0] mmd_addr;
    logic [MMD_MEM_DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] loopback;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic lrx_prev;
    logic [RX_DATA_W-1:0] tx_data;
    logic tx_en;
  } pss_regs_s;

  pss_regs_s st;
  pss_regs_s next_st;
  logic rst_meta;
  logic rst_n;
  logic [IDLE_CNT_W-1:0] idle_cnt;
  logic idle_inc;
  logic idle_clr;
  logic gs_rd;
  logic data_acc;
  logic [MMD_DEV_SEL_W+MMD_REG_SEL_W-1:0] idx;
  pss_mmd_mode_e mode;
  logic [DATA_W-1:0] gs_word;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_w1c;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status inputs come from PHY logic on this clock, so no synchroniser
  assign idle_inc = symbol_tick_i && rx_idle_i && rx_error_i
                    && (transmit_mode_indication_i == TXMODE_SEND_N); // [RULE7]
  assign gs_rd = rd_i && (addr_i == ADDR_GIG_STATUS);
  assign idle_clr = gs_rd; // [RULE6]

  pss_sat_cnt u_idle_cnt (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .inc_i(idle_inc),
    .clr_i(idle_clr),
    .count_o(idle_cnt)
  );

  // Only 2 device bits and 3 address bits reach storage: a small MMD window
  assign idx = {st.mmd_setup[MMD_DEV_SEL_W-1:0], st.mmd_addr[MMD_REG_SEL_W-1:0]}; // [RULE9]
  assign mode = pss_mmd_mode_e'(st.mmd_setup[MMD_MODE_HI:MMD_MODE_LO]); // [RULE8]
  assign data_acc = (rd_i || wr_i) && (addr_i == ADDR_MMD_DATA);

  assign gs_word = {st.ms_fault, ms_master_i, local_rx_ok_i, remote_rx_ok_i,
                    lp_1000_fd_i, lp_1000_hd_i, GS_RSVD_VAL, idle_cnt}; // [RULE2] [RULE3] [RULE4] [RULE5]

  assign irq_evt = {st.lrx_prev && !local_rx_ok_i, idle_inc, ms_fault_evt_i};
  assign irq_w1c = (wr_i && addr_i == ADDR_IRQ_STATUS) ? wdata_i[IRQ_W-1:0] : IRQ_RST;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    next_st.lrx_prev = local_rx_ok_i;

    if (rd_i) begin
      unique case (addr_i)
        ADDR_GIG_STATUS: next_st.rdata = gs_word;
        ADDR_MMD_SETUP: next_st.rdata = st.mmd_setup;
        ADDR_MMD_DATA: next_st.rdata = (mode == PSS_MMD_REG) ? st.mmd_addr : st.mem[idx]; // [RULE10] [RULE11]
        ADDR_EXT_STATUS: next_st.rdata = EXT_STATUS_VAL; // [RULE14]
        ADDR_LOOPBACK: next_st.rdata = st.loopback;
        ADDR_IRQ_STATUS: next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st.irq_status};
        ADDR_IRQ_MASK: next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st.irq_mask};
        default: next_st.rdata = '0;
      endcase
    end

    // Set after clear, so a fault in the read cycle survives
    if (gs_rd) begin
      next_st.ms_fault = 1'b0; // [RULE1]
    end
    if (ms_fault_evt_i) begin
      next_st.ms_fault = 1'b1; // [RULE1]
    end

    if (wr_i) begin
      unique case (addr_i)
        ADDR_MMD_SETUP: next_st.mmd_setup = wdata_i; // [RULE8] [RULE9]
        ADDR_LOOPBACK: next_st.loopback = {wdata_i[DATA_W-1:1], 1'b0}; // [RULE15]
        ADDR_IRQ_MASK: next_st.irq_mask = wdata_i[IRQ_W-1:0];
        default: next_st.mmd_setup = st.mmd_setup;
      endcase
    end
    // Reserved read-clear bit of the loopback register
    if (rd_i && addr_i == ADDR_LOOPBACK) begin
      next_st.loopback[LB_RC_BIT] = 1'b0;
    end

    if (data_acc) begin
      unique case (mode)
        PSS_MMD_REG: begin
          if (wr_i) begin
            next_st.mmd_addr = wdata_i; // [RULE10]
          end
        end
        PSS_MMD_DATA_NOINC: begin
          if (wr_i) begin
            next_st.mem[idx] = wdata_i; // [RULE11] [RULE13]
          end
        end
        PSS_MMD_DATA_INC_RW: begin
          if (wr_i) begin
            next_st.mem[idx] = wdata_i; // [RULE11]
          end
          next_st.mmd_addr = st.mmd_addr + MMD_ADDR_ONE; // [RULE12]
        end
        PSS_MMD_DATA_INC_W: begin
          if (wr_i) begin
            next_st.mem[idx] = wdata_i; // [RULE11]
            next_st.mmd_addr = st.mmd_addr + MMD_ADDR_ONE; // [RULE13]
          end
        end
      endcase
    end

    // Events win over a write-one-to-clear in the same cycle
    next_st.irq_status = (st.irq_status & ~irq_w1c) | irq_evt;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // Loopback bypasses the switch path entirely
    if (st.loopback[LB_BIT]) begin
      next_st.tx_data = rx_data_i; // [RULE15] [RULE16]
      next_st.tx_en = rx_dv_i; // [RULE16]
    end else begin
      next_st.tx_data = sw_tx_data_i;
      next_st.tx_en = sw_tx_en_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{rdata: '0, ms_fault: 1'b0, mmd_setup: MMD_SETUP_RST, mmd_addr: MMD_DATA_RST,
              mem: '0, loopback: LOOPBACK_RST, irq_status: IRQ_RST, irq_mask: IRQ_RST,
              irq: 1'b0, lrx_prev: 1'b0, tx_data: '0, tx_en: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign tx_data_o = st.tx_data;
  assign tx_en_o = st.tx_en;
  assign remote_loopback_o = st.loopback[LB_BIT];
  assign irq_o = st.irq;

  ////////////////////////////////////////////////////////////////////////////////
  property p_fault_set;
    @(posedge core_clk_i) disable iff (!rst_n)
      ms_fault_evt_i |=> rd_i && addr_i == ADDR_GIG_STATUS |=> rdata_o[GS_FAULT_BIT];
  endproperty
  a_fault_set: assert property (p_fault_set) // [RULE1]
    else $error("latched fault not reported on next read");

  property p_fault_clr;
    @(posedge core_clk_i) disable iff (!rst_n)
      gs_rd && !ms_fault_evt_i |=> !st.ms_fault;
  endproperty
  a_fault_clr: assert property (p_fault_clr) // [RULE1]
    else $error("fault flag not cleared by read");

  property p_master;
    @(posedge core_clk_i) disable iff (!rst_n)
      gs_rd |=> rdata_o[GS_MASTER_BIT] == $past(ms_master_i);
  endproperty
  a_master: assert property (p_master) // [RULE2]
    else $error("resolution bit wrong");

  property p_rx_health;
    @(posedge core_clk_i) disable iff (!rst_n)
      gs_rd |=> rdata_o[GS_LRX_BIT] == $past(local_rx_ok_i) && rdata_o[GS_RRX_BIT] == $past(remote_rx_ok_i);
  endproperty
  a_rx_health: assert property (p_rx_health) // [RULE3] [RULE4]
    else $error("receiver status bits wrong");

  property p_lp_caps;
    @(posedge core_clk_i) disable iff (!rst_n)
      gs_rd |=> rdata_o[GS_LPFD_BIT] == $past(lp_1000_fd_i) && rdata_o[GS_LPHD_BIT] == $past(lp_1000_hd_i);
  endproperty
  a_lp_caps: assert property (p_lp_caps) // [RULE5]
    else $error("partner capability bits wrong");

  property p_idle_clr;
    @(posedge core_clk_i) disable iff (!rst_n)
      gs_rd && !idle_inc |=> idle_cnt == IDLE_CNT_RST;
  endproperty
  a_idle_clr: assert property (p_idle_clr) // [RULE6]
    else $error("idle count not cleared by read");

  property p_idle_inc;
    @(posedge core_clk_i) disable iff (!rst_n)
      idle_inc && !idle_clr && idle_cnt != IDLE_CNT_MAX |=> idle_cnt == $past(idle_cnt) + IDLE_CNT_ONE;
  endproperty
  a_idle_inc: assert property (p_idle_inc) // [RULE7]
    else $error("idle count did not step");

  property p_setup_rd;
    @(posedge core_clk_i) disable iff (!rst_n)
      wr_i && addr_i == ADDR_MMD_SETUP ##1 rd_i && addr_i == ADDR_MMD_SETUP |=> rdata_o == $past(wdata_i, 2);
  endproperty
  a_setup_rd: assert property (p_setup_rd) // [RULE8] [RULE9]
    else $error("setup register readback wrong");

  property p_reg_mode;
    @(posedge core_clk_i) disable iff (!rst_n)
      wr_i && addr_i == ADDR_MMD_DATA && mode == PSS_MMD_REG |=> st.mmd_addr == $past(wdata_i);
  endproperty
  a_reg_mode: assert property (p_reg_mode) // [RULE10]
    else $error("register address not taken");

  property p_data_rd;
    @(posedge core_clk_i) disable iff (!rst_n)
      rd_i && addr_i == ADDR_MMD_DATA && mode != PSS_MMD_REG |=> rdata_o == $past(st.mem[idx]);
  endproperty
  a_data_rd: assert property (p_data_rd) // [RULE11]
    else $error("data read not from selected register");

  property p_inc_rw;
    @(posedge core_clk_i) disable iff (!rst_n)
      data_acc && mode == PSS_MMD_DATA_INC_RW |=> st.mmd_addr == $past(st.mmd_addr) + MMD_ADDR_ONE;
  endproperty
  a_inc_rw: assert property (p_inc_rw) // [RULE12]
    else $error("address not advanced");

  property p_no_inc;
    @(posedge core_clk_i) disable iff (!rst_n)
      data_acc && (mode == PSS_MMD_DATA_NOINC || (rd_i && mode == PSS_MMD_DATA_INC_W)) |=> $stable(st.mmd_addr);
  endproperty
  a_no_inc: assert property (p_no_inc) // [RULE13]
    else $error("address advanced when it must hold");

  property p_ext;
    @(posedge core_clk_i) disable iff (!rst_n)
      rd_i && addr_i == ADDR_EXT_STATUS |=> rdata_o == EXT_STATUS_VAL;
  endproperty
  a_ext: assert property (p_ext) // [RULE14]
    else $error("extended status value wrong");

  property p_loop;
    @(posedge core_clk_i) disable iff (!rst_n)
      st.loopback[LB_BIT] |=> tx_data_o == $past(rx_data_i) && tx_en_o == $past(rx_dv_i);
  endproperty
  a_loop: assert property (p_loop) // [RULE15] [RULE16]
    else $error("loopback path not taken");

  property p_fault_hold;
    @(posedge core_clk_i) disable iff (!rst_n)
      st.ms_fault && !gs_rd |=> st.ms_fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) // [RULE1]
    else $error("fault latch dropped without a read");

  property p_idle_field;
    @(posedge core_clk_i) disable iff (!rst_n)
      gs_rd |=> rdata_o[IDLE_CNT_W-1:0] == $past(idle_cnt) && rdata_o[GS_LPHD_BIT-1:IDLE_CNT_W] == GS_RSVD_VAL;
  endproperty
  a_idle_field: assert property (p_idle_field) // [RULE6]
    else $error("idle count field wrong");

  property p_inc_w;
    @(posedge core_clk_i) disable iff (!rst_n)
      data_acc && wr_i && mode == PSS_MMD_DATA_INC_W |=> st.mmd_addr == $past(st.mmd_addr) + MMD_ADDR_ONE;
  endproperty
  a_inc_w: assert property (p_inc_w) // [RULE13]
    else $error("address not advanced after write");

  property p_data_wr;
    @(posedge core_clk_i) disable iff (!rst_n)
      wr_i && addr_i == ADDR_MMD_DATA && mode != PSS_MMD_REG |=> st.mem[$past(idx)] == $past(wdata_i);
  endproperty
  a_data_wr: assert property (p_data_wr) // [RULE11]
    else $error("data write did not reach selected register");

  property p_loop_wr;
    @(posedge core_clk_i) disable iff (!rst_n)
      wr_i && addr_i == ADDR_LOOPBACK |=> remote_loopback_o == $past(wdata_i[LB_BIT]);
  endproperty
  a_loop_wr: assert property (p_loop_wr) // [RULE15]
    else $error("loopback enable not taken");

  property p_switch;
    @(posedge core_clk_i) disable iff (!rst_n)
      !st.loopback[LB_BIT] |=> tx_data_o == $past(sw_tx_data_i) && tx_en_o == $past(sw_tx_en_i);
  endproperty
  a_switch: assert property (p_switch) // [RULE15]
    else $error("switch path not taken in normal operation");
endmodule

/* inc/pss_pkg.sv */
// Package: register map, field layout, reset values and modes of the PHY status bank
package pss_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int IDLE_CNT_W = 8;
  localparam int IRQ_W = 3;
  localparam int RX_DATA_W = 8;
  localparam int MMD_MEM_DEPTH = 32;
  localparam int MMD_DEV_SEL_W = 2;
  localparam int MMD_REG_SEL_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_GIG_STATUS = 5'h0a;
  localparam logic [ADDR_W-1:0] ADDR_MMD_SETUP = 5'h0d;
  localparam logic [ADDR_W-1:0] ADDR_MMD_DATA = 5'h0e;
  localparam logic [ADDR_W-1:0] ADDR_EXT_STATUS = 5'h0f;
  localparam logic [ADDR_W-1:0] ADDR_LOOPBACK = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h19;

  localparam int GS_FAULT_BIT = 15;
  localparam int GS_MASTER_BIT = 14;
  localparam int GS_LRX_BIT = 13;
  localparam int GS_RRX_BIT = 12;
  localparam int GS_LPFD_BIT = 11;
  localparam int GS_LPHD_BIT = 10;
  localparam logic [1:0] GS_RSVD_VAL = 2'h0;

  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_RST = 8'h00;
  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_ONE = 8'h01;
  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_MAX = 8'hff;

  localparam int MMD_MODE_HI = 15;
  localparam int MMD_MODE_LO = 14;
  localparam logic [DATA_W-1:0] MMD_SETUP_RST = 16'h0000;
  localparam logic [DATA_W-1:0] MMD_DATA_RST = 16'h0000;
  localparam logic [DATA_W-1:0] MMD_ADDR_ONE = 16'h0001;

  typedef enum logic [1:0] {
    PSS_MMD_REG = 2'b00,
    PSS_MMD_DATA_NOINC = 2'b01,
    PSS_MMD_DATA_INC_RW = 2'b10,
    PSS_MMD_DATA_INC_W = 2'b11
  } pss_mmd_mode_e;

  localparam logic [DATA_W-1:0] EXT_STATUS_VAL = 16'h3000;

  localparam logic [DATA_W-1:0] LOOPBACK_RST = 16'h00f4;
  localparam int LB_BIT = 8;
  localparam int LB_RC_BIT = 1;

  localparam logic [1:0] TXMODE_SEND_N = 2'h0;

  localparam int IRQ_FAULT = 0;
  localparam int IRQ_IDLE_ERR = 1;
  localparam int IRQ_RX_LOST = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
endpackage

/* rtl/pss_sat_cnt.sv */
// Saturating idle error counter with clear-on-read
`timescale 1ns/1ps
module pss_sat_cnt
  import pss_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic inc_i,
  input wire logic clr_i,
  output logic [IDLE_CNT_W-1:0] count_o
);
  typedef struct packed {
    logic [IDLE_CNT_W-1:0] count;
  } pss_cnt_s;

  pss_cnt_s st;
  pss_cnt_s next_st;

  always_comb begin
    next_st = st;
    if (clr_i) begin
      // An error in the clearing cycle is kept, not lost
      next_st.count = inc_i ? IDLE_CNT_ONE : IDLE_CNT_RST; // [RULE6]
    end else if (inc_i && st.count != IDLE_CNT_MAX) begin
      next_st.count = st.count + IDLE_CNT_ONE; // [RULE7] [RULE17]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{count: IDLE_CNT_RST};
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.count;

  property p_sat_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st.count == IDLE_CNT_MAX) && !clr_i |=> st.count == IDLE_CNT_MAX;
  endproperty
  a_sat_hold: assert property (p_sat_hold) // [RULE17]
    else $error("idle counter left saturation without clear");
endmodule

/* testbench/test_pss_phy_regs.sv */
// Self-checking bench for the per-port PHY status, MMD, loopback and interrupt registers
`timescale 1ns/1ps
module test_pss_phy_regs
  import pss_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0, rd = 1'b0, fault = 1'b0, ms = 1'b0, lrx = 1'b1, rrx = 1'b0, fd = 1'b0, hd = 1'b0;
  logic tick = 1'b0, idle = 1'b0, rxer = 1'b0, rx_dv = 1'b0, sw_en = 1'b0;
  logic [1:0] tmi = 2'h0;
  logic [RX_DATA_W-1:0] rx_data = '0, sw_data = '0;
  logic [DATA_W-1:0] rdata, got;
  logic [RX_DATA_W-1:0] tx_data;
  logic tx_en, lb, irq;
  logic [31:0] seed = 32'd45;
  int n_fail = 0;
  int num_checks = 0;
  logic [DATA_W-1:0] d0, d1;

  always #12.5 clk = ~clk;

  pss_phy_regs dut (.core_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .ms_fault_evt_i(fault), .ms_master_i(ms), .local_rx_ok_i(lrx), .remote_rx_ok_i(rrx),
    .lp_1000_fd_i(fd), .lp_1000_hd_i(hd), .symbol_tick_i(tick), .rx_idle_i(idle),
    .transmit_mode_indication_i(tmi), .rx_error_i(rxer), .rx_data_i(rx_data), .rx_dv_i(rx_dv),
    .sw_tx_data_i(sw_data), .sw_tx_en_i(sw_en), .tx_data_o(tx_data), .tx_en_o(tx_en),
    .remote_loopback_o(lb), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected gigabit status word from live inputs, latch and count
  function automatic logic [DATA_W-1:0] exp_gs(input logic f, input logic [IDLE_CNT_W-1:0] c);
    return {f, ms, lrx, rrx, fd, hd, GS_RSVD_VAL, c};
  endfunction

  function automatic logic [IDLE_CNT_W-1:0] sat(input int n);
    return (n > 255) ? IDLE_CNT_MAX : n[IDLE_CNT_W-1:0];
  endfunction

  task automatic chk16(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe; sampled just after that edge
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd_reg(a, got);
    chk16(got, e);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
    end
    @(posedge clk);
    tick <= 1'b0;
  endtask

  task automatic pulse_fault();
    @(posedge clk);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk16(rdata, 16'h0000);
    chk1(lb, 1'b0);
    chk1(irq, 1'b0);
    rd_chk(ADDR_EXT_STATUS, EXT_STATUS_VAL);
    rd_chk(ADDR_MMD_SETUP, MMD_SETUP_RST);
    rd_chk(ADDR_MMD_DATA, MMD_DATA_RST);
    rd_chk(ADDR_LOOPBACK, LOOPBACK_RST);
    rd_chk(5'h1f, 16'h0000);
    wr_reg(ADDR_EXT_STATUS, 16'hffff);
    rd_chk(ADDR_EXT_STATUS, EXT_STATUS_VAL);
    $display("test reset_values done");

    // Live status bits under random levels; a receiver drop here is cleared before the irq test
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      @(posedge clk);
      {ms, lrx, rrx, fd, hd} <= seed[4:0];
      // New levels must land before the expectation reads them
      #1;
      rd_chk(ADDR_GIG_STATUS, exp_gs(1'b0, IDLE_CNT_RST));
    end
    lrx <= 1'b1;
    pulse_fault();
    repeat (4) @(posedge clk);
    rd_chk(ADDR_GIG_STATUS, exp_gs(1'b1, IDLE_CNT_RST));
    rd_chk(ADDR_GIG_STATUS, exp_gs(1'b0, IDLE_CNT_RST));
    $display("test gig_status done");

    @(posedge clk);
    idle <= 1'b1;
    rxer <= 1'b1;
    tmi <= TXMODE_SEND_N;
    ticks(5);
    tmi <= 2'h1;
    ticks(3);
    tmi <= TXMODE_SEND_N;
    rxer <= 1'b0;
    ticks(2);
    rxer <= 1'b1;
    idle <= 1'b0;
    ticks(2);
    idle <= 1'b1;
    rd_chk(ADDR_GIG_STATUS, exp_gs(1'b0, sat(5)));
    rd_chk(ADDR_GIG_STATUS, exp_gs(1'b0, IDLE_CNT_RST));
    ticks(260);
    rd_chk(ADDR_GIG_STATUS, exp_gs(1'b0, sat(260)));
    rd_chk(ADDR_GIG_STATUS, exp_gs(1'b0, IDLE_CNT_RST));
    rxer <= 1'b0;
    $display("test idle_count done");

    // Indirect access: device 2, register 3, then each data mode in turn
    seed = xs(seed);
    d0 = seed[15:0];
    d1 = seed[31:16];
    wr_reg(ADDR_MMD_SETUP, 16'h0002);
    rd_chk(ADDR_MMD_SETUP, 16'h0002);
    wr_reg(ADDR_MMD_DATA, 16'h0003);
    rd_chk(ADDR_MMD_DATA, 16'h0003);
    wr_reg(ADDR_MMD_SETUP, 16'h8002);
    rd_chk(ADDR_MMD_SETUP, 16'h8002);
    wr_reg(ADDR_MMD_DATA, d0);
    wr_reg(ADDR_MMD_DATA, d1);
    wr_reg(ADDR_MMD_SETUP, 16'h0002);
    rd_chk(ADDR_MMD_DATA, 16'h0005);
    wr_reg(ADDR_MMD_DATA, 16'h0003);
    wr_reg(ADDR_MMD_SETUP, 16'h4002);
    rd_chk(ADDR_MMD_DATA, d0);
    rd_chk(ADDR_MMD_DATA, d0);
    // A new value, so a lost write shows; a stray advance reads register 4, which also holds d1
    wr_reg(ADDR_MMD_DATA, d1);
    rd_chk(ADDR_MMD_DATA, d1);
    wr_reg(ADDR_MMD_SETUP, 16'hc002);
    rd_chk(ADDR_MMD_DATA, d1);
    wr_reg(ADDR_MMD_DATA, d0);
    rd_chk(ADDR_MMD_DATA, d1);
    wr_reg(ADDR_MMD_SETUP, 16'h8002);
    rd_chk(ADDR_MMD_DATA, d1);
    wr_reg(ADDR_MMD_SETUP, 16'h0002);
    rd_chk(ADDR_MMD_DATA, 16'h0005);
    wr_reg(ADDR_MMD_DATA, 16'h0003);
    wr_reg(ADDR_MMD_SETUP, 16'h4002);
    rd_chk(ADDR_MMD_DATA, d0);
    $display("test mmd done");

    wr_reg(ADDR_LOOPBACK, 16'h0103);
    #1;
    chk1(lb, 1'b1);
    rd_chk(ADDR_LOOPBACK, 16'h0102);
    rd_chk(ADDR_LOOPBACK, 16'h0100);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      @(posedge clk);
      {rx_dv, rx_data, sw_en, sw_data} <= seed[17:0];
      @(posedge clk);
      #1;
      chk16({7'h00, tx_en, tx_data}, {7'h00, rx_dv, rx_data});
    end
    wr_reg(ADDR_LOOPBACK, LOOPBACK_RST);
    #1;
    chk1(lb, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge clk);
      {rx_dv, rx_data, sw_en, sw_data} <= seed[17:0];
      @(posedge clk);
      #1;
      chk16({7'h00, tx_en, tx_data}, {7'h00, sw_en, sw_data});
    end
    $display("test loopback done");

    wr_reg(ADDR_IRQ_STATUS, 16'h0007);
    wr_reg(ADDR_IRQ_MASK, 16'h0001);
    pulse_fault();
    chk1(irq, 1'b1);
    rd_chk(ADDR_IRQ_STATUS, 16'h0001);
    wr_reg(ADDR_IRQ_STATUS, 16'h0001);
    @(posedge clk);
    #1;
    chk1(irq, 1'b0);
    @(posedge clk);
    lrx <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk1(irq, 1'b0);
    rd_chk(ADDR_IRQ_STATUS, 16'h0004);
    wr_reg(ADDR_IRQ_MASK, 16'h0004);
    @(posedge clk);
    #1;
    chk1(irq, 1'b1);
    wr_reg(ADDR_IRQ_STATUS, 16'h0004);
    @(posedge clk);
    #1;
    chk1(irq, 1'b0);
    $display("test irq done");
    conclude();
  end
endmodule
